//--- rtl/dss_speed_select.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - codes 00/01 give forward/reverse run
// - codes 02-05 form binary speed index
// - index n selects preset n plus one
// - jog select overrides the four index inputs
// - preset one from keypad or analog input
// - PID enable disables preset speed selection
// - codes 06/07 jog forward/reverse at jog
// - active jog overrides every reference source
// - jog beyond 500 ms stops by mode
// - step up/down act only with source 2
// - stepping ramps with selected time set
// - error when only one step function assigned
// - error when both step inputs active
// - run plus step pulse reaches lower limit
// - stepping clamps between upper and lower limits
// - retention 1 saves and restores reference
// - retention 1 run accelerates to stored reference
// - retention 0 run accelerates to lower limit
// - codes 10/30 choose the ramp time set
// - ramp hold freezes output, release resumes
// - retention 1 hold stores reference for run
// - retention 0 hold at run keeps zero
// - each terminal has its own function code
module dss_speed_select
  import dss_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S,
  parameter int unsigned JOG_MS = JOG_LIMIT_MS
)
(
  input wire logic ref_clk_i,                       // 40 MHz clock
  input wire logic rst_n_i,                         // async reset
  input wire logic [TERM_N-1:0] term_i,             // terminal pins
  input wire logic [TERM_N-1:0][CODE_W-1:0] code_i, // codes per pin
  input wire logic [1:0] freq_src_i,                // source setting
  input wire logic pid_en_i,                        // PID enabled
  input wire logic retain_en_i,                     // retention set
  input wire logic [PRESET_N-1:0][FREQ_W-1:0] preset_i, // presets
  input wire logic [FREQ_W-1:0] analog_ref_i,       // analog one/two
  input wire logic [FREQ_W-1:0] jog_freq_i,         // jog frequency
  input wire logic [FREQ_W-1:0] upper_lim_i,        // upper limit
  input wire logic [FREQ_W-1:0] lower_lim_i,        // lower limit
  input wire logic [TIME_W-1:0] accel_time_set_one_i, // step period in ms, less one
  input wire logic [TIME_W-1:0] decel_time_set_one_i, // step period in ms, less one
  input wire logic [TIME_W-1:0] accel_time_set_two_i, // step period in ms, less one
  input wire logic [TIME_W-1:0] decel_time_set_two_i, // step period in ms, less one
  input wire logic power_fail_i,                    // supply lost pin
  input wire logic [FREQ_W-1:0] nv_ref_i,           // stored ref
  output logic run_o,                               // motor runs
  output logic reverse_o,                           // reverse dir
  output logic jog_stop_o,                          // stop by mode
  output logic [FREQ_W-1:0] freq_ref_o,             // reference
  output logic [FREQ_W-1:0] out_freq_o,             // ramp output
  output logic ramp_set_two_o,                      // set two used
  output logic input_config_error_o,                // config error
  output logic nv_save_o,                           // save pulse
  output logic [FREQ_W-1:0] nv_ref_o                // value to save
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic [TERM_N-1:0] s1;
    logic [TERM_N-1:0] s2;
    logic [TERM_N-1:0] s3;
    logic [TERM_N-1:0] term;
    logic [2:0] pf_sync;
    logic pf;
    dss_state_t state;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [JOG_CNT_W-1:0] jog_ms;
    logic [TIME_W-1:0] ramp_ms;
    logic [FREQ_W-1:0] out_freq;
    logic [FREQ_W-1:0] ud_ref;
    logic [FREQ_W-1:0] freq_ref;
    logic restored;
    logic zero_hold;
    logic hold_start;
    logic hold_q;
    logic step_q;
    logic nv_save;
    logic [FREQ_W-1:0] nv_ref;
    logic err;
    logic set_two;
  } dss_st_t;

  dss_st_t st_r;
  dss_st_t st_nxt;

  // ==========================================================
  // helpers

  // terminals that carry a given function code
  function automatic logic [TERM_N-1:0] code_mask
    (input logic [TERM_N-1:0][CODE_W-1:0] codes,
     input logic [CODE_W-1:0] fc);
    logic [TERM_N-1:0] m;
    m = '0;
    for (int i = 0; i < TERM_N; i++)
    begin
      m[i] = (codes[i] == fc);
    end
    return m;
  endfunction : code_mask

  // any terminal with this code is on
  function automatic logic code_on
    (input logic [TERM_N-1:0][CODE_W-1:0] codes,
     input logic [TERM_N-1:0] lvl,
     input logic [CODE_W-1:0] fc);
    return |(code_mask(codes, fc) & lvl);
  endfunction : code_on

  // clamp a frequency into the limit window
  function automatic logic [FREQ_W-1:0] clamp
    (input logic [FREQ_W-1:0] f,
     input logic [FREQ_W-1:0] lo,
     input logic [FREQ_W-1:0] hi);
    logic [FREQ_W-1:0] r;
    r = f;
    if (r > hi)
    begin
      r = hi;
    end
    if (r < lo)
    begin
      r = lo;
    end
    return r;
  endfunction : clamp

  // ==========================================================
  // decoded terminal functions
  logic fwd;
  logic rev;
  logic jog_f;
  logic jog_r;
  logic jog_sel;
  logic up;
  logic dn;
  logic hold;
  logic up_asg;
  logic dn_asg;
  logic [IDX_W-1:0] idx;
  logic ms_tick;
  logic run_cmd;
  logic step_mode;
  logic [FREQ_W-1:0] preset_sel;
  logic [FREQ_W-1:0] target;
  logic [TIME_W-1:0] t_acc;
  logic [TIME_W-1:0] t_dec;

  // decode the filtered terminal levels through their codes
  always_comb
  begin
    fwd = code_on(code_i, st_r.term, FC_FWD_RUN);
    rev = code_on(code_i, st_r.term, FC_REV_RUN);
    jog_f = code_on(code_i, st_r.term, FC_JOG_FWD);
    jog_r = code_on(code_i, st_r.term, FC_JOG_REV);
    jog_sel = code_on(code_i, st_r.term, FC_JOG_SEL);
    up = code_on(code_i, st_r.term, FC_STEP_UP);
    dn = code_on(code_i, st_r.term, FC_STEP_DOWN);
    hold = code_on(code_i, st_r.term, FC_RAMP_HOLD);
    up_asg = |code_mask(code_i, FC_STEP_UP);
    dn_asg = |code_mask(code_i, FC_STEP_DOWN);
    // bit 0 is the lowest code of the group
    idx = {code_on(code_i, st_r.term, FC_SPEED_B3),
           code_on(code_i, st_r.term, FC_SPEED_B2),
           code_on(code_i, st_r.term, FC_SPEED_B1),
           code_on(code_i, st_r.term, FC_SPEED_B0)};
    // PID owns the reference, so the index is forced off
    if (pid_en_i)
    begin
      idx = '0;
    end
    ms_tick = (st_r.ms_cnt == MS_CNT_W'(CYC_PER_MS - 1));
    run_cmd = fwd | rev;
    // stepping needs source 2 and both functions assigned
    step_mode = (freq_src_i == SRC_STEP) & up_asg & dn_asg;
  end

  // ==========================================================
  // reference selection: jog first, then step, then presets
  always_comb
  begin
    // index n picks entry n, i.e. preset number n plus one
    preset_sel = preset_i[idx];
    if (idx == '0)
    begin
      preset_sel = (freq_src_i == SRC_ANALOG) ? analog_ref_i
                                              : preset_i[0];
    end
    if (jog_f | jog_r | jog_sel)
    begin
      target = jog_freq_i;
    end
    else if (step_mode)
    begin
      target = st_r.ud_ref;
    end
    else
    begin
      target = preset_sel;
    end
    if (st_r.zero_hold)
    begin
      target = '0;
    end
  end

  // ramp time set: set two only while its input is on
  always_comb
  begin
    t_acc = st_r.set_two ? accel_time_set_two_i
                         : accel_time_set_one_i;
    t_dec = st_r.set_two ? decel_time_set_two_i
                         : decel_time_set_one_i;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.nv_save = 1'b0;

    // three stage filter: a change counts once s2 and s3 agree
    st_nxt.s1 = term_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < TERM_N; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
      begin
        st_nxt.term[i] = st_r.s3[i];
      end
    end
    st_nxt.pf_sync = {st_r.pf_sync[1:0], power_fail_i};
    if (st_r.pf_sync[1] == st_r.pf_sync[2])
    begin
      st_nxt.pf = st_r.pf_sync[2];
    end

    // millisecond enable
    st_nxt.ms_cnt = ms_tick ? '0 : st_r.ms_cnt + 1'b1;

    // selection between the two ramp sets; set one wins
    st_nxt.set_two = code_on(code_i, st_r.term, FC_RAMP_SET2) &
                     ~code_on(code_i, st_r.term, FC_RAMP_SET1);

    // misuse of the step inputs is flagged as a level
    st_nxt.err = (up_asg ^ dn_asg) | (up & dn);

    // stored reference comes back once, after reset release
    if (!st_r.restored)
    begin
      st_nxt.restored = 1'b1;
      st_nxt.ud_ref = retain_en_i ? nv_ref_i : '0;
      st_nxt.nv_ref = nv_ref_i;
    end

    // save on supply loss, and when hold engages
    st_nxt.hold_q = hold;
    if (retain_en_i && ((st_nxt.pf && !st_r.pf) ||
                        (hold && !st_r.hold_q)))
    begin
      st_nxt.nv_save = 1'b1;
      st_nxt.nv_ref = st_r.freq_ref;
    end

    // step up/down, one unit per millisecond tick
    st_nxt.step_q = up | dn;
    if (step_mode && run_cmd && !st_r.err)
    begin
      if ((up | dn) && !st_r.step_q && st_r.ud_ref < lower_lim_i)
      begin
        st_nxt.ud_ref = lower_lim_i;
      end
      else if (ms_tick && up && !dn)
      begin
        if (st_r.ud_ref < upper_lim_i)
        begin
          st_nxt.ud_ref = st_r.ud_ref + 1'b1;
        end
      end
      else if (ms_tick && dn && !up)
      begin
        if (st_r.ud_ref > lower_lim_i)
        begin
          st_nxt.ud_ref = st_r.ud_ref - 1'b1;
        end
      end
      st_nxt.ud_ref = clamp(st_nxt.ud_ref, lower_lim_i,
                            upper_lim_i);
    end

    // run sequencer
    case (st_r.state)
      DSS_IDLE:
      begin
        st_nxt.jog_ms = '0;
        if (jog_f | jog_r)
        begin
          st_nxt.state = DSS_JOG;
        end
        else if (run_cmd)
        begin
          st_nxt.state = DSS_RUN;
          // start value of the stepped reference
          if (step_mode && !retain_en_i)
          begin
            st_nxt.ud_ref = lower_lim_i;
          end
          else if (step_mode)
          begin
            st_nxt.ud_ref = st_r.nv_ref;
          end
          st_nxt.zero_hold = hold & ~retain_en_i;
          // a run begun under hold still climbs to the stored reference
          st_nxt.hold_start = hold & retain_en_i;
        end
      end
      DSS_RUN:
      begin
        if (!hold)
        begin
          st_nxt.zero_hold = 1'b0;
          st_nxt.hold_start = 1'b0;
        end
        if (!run_cmd)
        begin
          st_nxt.state = DSS_IDLE;
          st_nxt.zero_hold = 1'b0;
          st_nxt.hold_start = 1'b0;
        end
      end
      DSS_JOG:
      begin
        if (ms_tick)
        begin
          st_nxt.jog_ms = st_r.jog_ms + 1'b1;
        end
        if (!(jog_f | jog_r))
        begin
          st_nxt.state = DSS_IDLE;
        end
        else if (st_r.jog_ms > JOG_CNT_W'(JOG_MS))
        begin
          st_nxt.state = DSS_JOG_STOP;
        end
      end
      DSS_JOG_STOP:
      begin
        // stays stopped until the jog input is released
        if (!(jog_f | jog_r))
        begin
          st_nxt.state = DSS_IDLE;
        end
      end
      default:
      begin
        st_nxt.state = DSS_IDLE;
      end
    endcase

    // reference register and output ramp
    st_nxt.freq_ref = target;
    if (st_r.state == DSS_IDLE || st_r.state == DSS_JOG_STOP)
    begin
      st_nxt.ramp_ms = '0;
      if (st_r.out_freq != '0 && ms_tick)
      begin
        st_nxt.out_freq = st_r.out_freq - 1'b1;
      end
    end
    else if (hold && !st_r.hold_start)
    begin
      st_nxt.ramp_ms = '0;
    end
    else if (ms_tick)
    begin
      // one frequency unit per ramp time plus one, in milliseconds
      if (st_r.ramp_ms >= ((target > st_r.out_freq) ? t_acc : t_dec))
      begin
        st_nxt.ramp_ms = '0;
        if (target > st_r.out_freq)
        begin
          st_nxt.out_freq = st_r.out_freq + 1'b1;
        end
        else if (target < st_r.out_freq)
        begin
          st_nxt.out_freq = st_r.out_freq - 1'b1;
        end
      end
      else
      begin
        st_nxt.ramp_ms = st_r.ramp_ms + 1'b1;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '0;
      st_r.state <= DSS_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign run_o = (st_r.state == DSS_RUN) || (st_r.state == DSS_JOG);
  assign reverse_o = (st_r.state == DSS_JOG) ? jog_r & ~jog_f
                                             : rev & ~fwd;
  assign jog_stop_o = (st_r.state == DSS_JOG_STOP);
  assign freq_ref_o = st_r.freq_ref;
  assign out_freq_o = st_r.out_freq;
  assign ramp_set_two_o = st_r.set_two;
  assign input_config_error_o = st_r.err;
  assign nv_save_o = st_r.nv_save;
  assign nv_ref_o = st_r.nv_ref;

endmodule : dss_speed_select

`default_nettype wire

//--- rtl/dss_pkg.sv
// ============================================================
// shared constants for the digital input speed select block
package dss_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned TERM_N = 6;         // input terminals
  localparam int unsigned CODE_W = 7;         // function code width
  localparam int unsigned FREQ_W = 16;        // frequency word width
  localparam int unsigned TIME_W = 16;        // ramp time word width
  localparam int unsigned IDX_W = 4;          // preset speed index
  localparam int unsigned PRESET_N = 16;      // number of presets

  // ==========================================================
  // terminal function codes
  localparam logic [6:0] FC_FWD_RUN = 7'h00;
  localparam logic [6:0] FC_REV_RUN = 7'h01;
  localparam logic [6:0] FC_SPEED_B0 = 7'h02;
  localparam logic [6:0] FC_SPEED_B1 = 7'h03;
  localparam logic [6:0] FC_SPEED_B2 = 7'h04;
  localparam logic [6:0] FC_SPEED_B3 = 7'h05;
  localparam logic [6:0] FC_JOG_FWD = 7'h06;
  localparam logic [6:0] FC_JOG_REV = 7'h07;
  localparam logic [6:0] FC_STEP_UP = 7'h08;
  localparam logic [6:0] FC_STEP_DOWN = 7'h09;
  localparam logic [6:0] FC_RAMP_SET1 = 7'h0A;
  localparam logic [6:0] FC_RAMP_HOLD = 7'h0B;
  localparam logic [6:0] FC_JOG_SEL = 7'h1D;
  localparam logic [6:0] FC_RAMP_SET2 = 7'h1E;

  // ==========================================================
  // frequency source setting values
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] SRC_STEP = 2'h2;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 40_000_000;  // ref_clk_i rate
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned JOG_LIMIT_MS = 500;   // longest jog, ms
  localparam int unsigned MS_CNT_W = 20;
  localparam int unsigned JOG_CNT_W = 12;

  // ==========================================================
  // run sequencer states
  typedef enum logic [3:0] {
    DSS_IDLE = 4'h1,
    DSS_RUN = 4'h2,
    DSS_JOG = 4'h4,
    DSS_JOG_STOP = 4'h8
  } dss_state_t;

endpackage : dss_pkg

//--- dv/dss_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// switch bank on the input terminals
module dss_switch_model
(
  input wire logic clk_i,         // bench clock
  input wire logic [5:0] want_i,  // requested contact state
  output logic [5:0] term_o       // terminal pins
);
  // contacts move just after an edge; each pin has its own switch
  always_ff @(posedge clk_i)
    term_o <= want_i;
endmodule : dss_switch_model
`default_nettype wire

//--- dv/dss_sel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks for the speed select block
module dss_sel_asserts
  import dss_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = 4,
  parameter int unsigned JOG_MS = 5
)
(
  input wire logic ref_clk_i,                       // clock
  input wire logic rst_n_i,                         // reset
  input wire logic [TERM_N-1:0] term_i,             // pins
  input wire logic [TERM_N-1:0][CODE_W-1:0] code_i, // codes
  input wire logic [1:0] freq_src_i,                // source
  input wire logic retain_en_i,                     // retention
  input wire logic [FREQ_W-1:0] jog_freq_i,         // jog freq
  input wire logic [FREQ_W-1:0] upper_lim_i,        // upper limit
  input wire logic run_o,                           // running
  input wire logic jog_stop_o,                      // jog expired
  input wire logic [FREQ_W-1:0] freq_ref_o,         // reference
  input wire logic [FREQ_W-1:0] out_freq_o,         // ramp output
  input wire logic input_config_error_o,            // config error
  input wire logic nv_save_o                        // save pulse
);
  // jog must be stopped by then; pin filter and tick phase included
  localparam int unsigned JOG_LIM = (JOG_MS + 3) * CYC_PER_MS + 8;
  logic [11:0] jog_cnt_r;
  logic [3:0] hold_cnt_r;
  logic jog_on;
  logic hold_on;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // raw level of pins carrying a code, ahead of the filter
  function automatic logic lvl(input logic [CODE_W-1:0] fc);
    lvl = 1'b0;
    for (int k = 0; k < TERM_N; k++)
      lvl |= term_i[k] & (code_i[k] == fc);
  endfunction : lvl

  // some pin is programmed with the code
  function automatic logic asg(input logic [CODE_W-1:0] fc);
    asg = 1'b0;
    for (int k = 0; k < TERM_N; k++)
      asg |= code_i[k] == fc;
  endfunction : asg

  // jog without the forward run pin, hold while forward run is on
  always_comb
  begin
    jog_on = (lvl(FC_JOG_FWD) | lvl(FC_JOG_REV)) & ~lvl(FC_FWD_RUN);
    hold_on = lvl(FC_RAMP_HOLD) & lvl(FC_FWD_RUN);
  end

  // saturating cycle counts of the two conditions
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      jog_cnt_r <= '0;
      hold_cnt_r <= '0;
    end
    else
    begin
      if (!jog_on)
        jog_cnt_r <= '0;
      else if (jog_cnt_r != 12'(JOG_LIM))
        jog_cnt_r <= jog_cnt_r + 12'h001;
      if (!hold_on)
        hold_cnt_r <= '0;
      else if (hold_cnt_r != 4'h8)
        hold_cnt_r <= hold_cnt_r + 4'h1;
    end
  end

  // ==========================================================
  // assertions
  property p_save_pulse;
    nv_save_o |=> !nv_save_o;
  endproperty
  a_save_pulse: assert property (p_save_pulse)
    else $error("save pulse longer than one cycle");

  property p_out_step;
    $changed(out_freq_o) && !jog_stop_o && !$past(jog_stop_o) |->
      out_freq_o == $past(out_freq_o) + 16'h0001 ||
      out_freq_o == $past(out_freq_o) - 16'h0001;
  endproperty
  a_out_step: assert property (p_out_step)
    else $error("output frequency jumped");

  property p_hold;
    hold_cnt_r == 4'h8 && !retain_en_i |-> $stable(out_freq_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved during ramp hold");

  property p_jog_stop;
    jog_cnt_r == 12'(JOG_LIM) |-> jog_stop_o;
  endproperty
  a_jog_stop: assert property (p_jog_stop)
    else $error("long jog not stopped");

  property p_err_one;
    (asg(FC_STEP_UP) != asg(FC_STEP_DOWN))[*3] |-> input_config_error_o;
  endproperty
  a_err_one: assert property (p_err_one)
    else $error("single step function not flagged");

  property p_err_both;
    (lvl(FC_STEP_UP) && lvl(FC_STEP_DOWN))[*6] |=> input_config_error_o;
  endproperty
  a_err_both: assert property (p_err_both)
    else $error("both step inputs not flagged");

  property p_run;
    (lvl(FC_FWD_RUN) && !jog_stop_o)[*7] |-> run_o;
  endproperty
  a_run: assert property (p_run)
    else $error("forward run pin did not run");

  property p_jog_sel;
    (lvl(FC_JOG_SEL) && freq_src_i != SRC_STEP)[*7] |->
      freq_ref_o == jog_freq_i;
  endproperty
  a_jog_sel: assert property (p_jog_sel)
    else $error("jog select did not pick jog frequency");

  property p_clamp;
    freq_src_i == SRC_STEP |-> out_freq_o <= upper_lim_i;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("stepped output above upper limit");
endmodule : dss_sel_asserts
`default_nettype wire

//--- dv/dss_testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// top bench for the speed select block
module testbench;
  import dss_pkg::*;
  typedef struct packed {logic [1:0] s; logic [15:0] v;} dss_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] want = '0;
  logic [5:0] term;
  logic [5:0][6:0] code = '0;
  logic [1:0] src = SRC_KEYPAD;
  logic pid = 1'b0;
  logic ret = 1'b0;
  logic [15:0] t1 = 16'h0000;
  logic [15:0] t2 = 16'h0001;
  logic [15:0] hi = 16'h0018;
  logic [15:0] lo = 16'h000A;
  logic [15:0][15:0] pre;
  logic [15:0] ana, jogf, nv, fref, fout;
  logic run, rev, jst, set2, err;
  logic pf = 1'b0;
  logic [15:0] nvo;
  int fails = 0;
  int samples_checked = 0;
  int seed = 32'h735c;
  string nm [4] = '{"freq_ref", "out_freq", "flags", "nv_ref"};
  dss_note_t q[$];
  dss_note_t nt;

  // 40 MHz reference clock
  always #12.5 clk = ~clk;

  dss_switch_model sw (.clk_i(clk), .want_i(want), .term_o(term));

  // short ms tick and jog limit keep the run brief
  dss_speed_select #(.CYC_PER_MS(4), .JOG_MS(5)) dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .term_i(term), .code_i(code),
    .freq_src_i(src), .pid_en_i(pid), .retain_en_i(ret),
    .preset_i(pre), .analog_ref_i(ana), .jog_freq_i(jogf),
    .upper_lim_i(hi), .lower_lim_i(lo), .accel_time_set_one_i(t1),
    .decel_time_set_one_i(t1), .accel_time_set_two_i(t2),
    .decel_time_set_two_i(t2), .power_fail_i(pf), .nv_ref_i(nv),
    .run_o(run), .reverse_o(rev), .jog_stop_o(jst), .freq_ref_o(fref),
    .out_freq_o(fout), .ramp_set_two_o(set2),
    .input_config_error_o(err), .nv_save_o(), .nv_ref_o(nvo));

  function automatic logic [15:0] seen(input logic [1:0] s);
    case (s)
      2'h0: seen = fref;
      2'h1: seen = fout;
      2'h2: seen = {11'h000, run, rev, jst, set2, err};
      default: seen = nvo;
    endcase
  endfunction : seen

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input logic [1:0] s, input logic [15:0] v);
    samples_checked++;
    if (seen(s) !== v)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm[s], v, seen(s));
    end
  endtask : check

  // note an expectation; the monitor compares it at the falling edge
  task automatic note(input logic [1:0] s, input logic [15:0] v);
    q.push_back('{s, v});
    cyc(1);
  endtask : note

  // bounded wait for a value, then note it
  task automatic wait_for(input logic [1:0] s, input logic [15:0] v);
    int i;
    for (i = 0; i < 600 && seen(s) !== v; i++)
      cyc(1);
    if (i == 600)
    begin
      fails++;
      $display("FAIL %s wait expected %h seen %h", nm[s], v, seen(s));
      finish_test();
    end
    note(s, v);
  endtask : wait_for

  task automatic set_codes(input logic [6:0] a, b, c, d, e, f);
    code <= {f, e, d, c, b, a};
  endtask : set_codes

  task automatic do_reset(input logic [15:0] stored);
    rst_n <= 1'b0;
    want <= 6'h00;
    nv <= stored;
    cyc(8);
    rst_n <= 1'b1;
    cyc(2);
  endtask : do_reset

  // outputs are settled at the falling edge
  always @(negedge clk)
    while (q.size() > 0)
    begin
      nt = q.pop_front();
      check(nt.s, nt.v);
    end

  // ==========================================================
  // scenarios
  initial
  begin
    for (int n = 0; n < 16; n++)
      pre[n] <= 16'($random(seed));
    ana <= 16'($random(seed));
    jogf <= 16'($random(seed));
    nv <= 16'h0000;
    cyc(8);
    rst_n <= 1'b1;
    cyc(2);
    set_codes(FC_FWD_RUN, FC_REV_RUN, FC_SPEED_B0, FC_SPEED_B1,
      FC_SPEED_B2, FC_SPEED_B3);
    for (int n = 0; n < 16; n++)
    begin
      want <= {n[3:0], 2'b01};
      cyc(10);
      note(2'h0, pre[n]);
    end
    note(2'h2, 16'h0010);
    src <= SRC_ANALOG;
    want <= 6'h01;
    cyc(10);
    note(2'h0, ana);
    pid <= 1'b1;
    want <= 6'h25;
    cyc(10);
    note(2'h0, ana);
    pid <= 1'b0;
    want <= 6'h02;
    cyc(10);
    note(2'h2, 16'h0018);
    $display("test presets done");
    src <= SRC_KEYPAD;
    set_codes(FC_FWD_RUN, FC_JOG_SEL, FC_SPEED_B0, FC_SPEED_B1,
      FC_SPEED_B2, FC_SPEED_B3);
    want <= 6'h3F;
    cyc(10);
    note(2'h0, jogf);
    want <= 6'h3D;
    cyc(10);
    note(2'h0, pre[15]);
    want <= 6'h00;
    cyc(10);
    // jog forward with index three also asked
    set_codes(FC_JOG_FWD, FC_JOG_REV, FC_SPEED_B0, FC_SPEED_B1,
      FC_SPEED_B2, FC_SPEED_B3);
    want <= 6'h0D;
    cyc(10);
    note(2'h0, jogf);
    note(2'h2, 16'h0010);
    wait_for(2'h2, 16'h0004);
    want <= 6'h00;
    cyc(10);
    want <= 6'h02;
    cyc(10);
    note(2'h2, 16'h0018);
    $display("test jog done");
    do_reset(16'h0000);
    src <= SRC_STEP;
    set_codes(FC_FWD_RUN, FC_REV_RUN, FC_STEP_UP, FC_RAMP_SET1,
      FC_RAMP_SET2, FC_RAMP_HOLD);
    cyc(10);
    note(2'h2, 16'h0001);
    code[3] <= FC_STEP_DOWN;
    cyc(10);
    note(2'h2, 16'h0000);
    want <= 6'h01;
    wait_for(2'h1, lo);
    want <= 6'h05;
    wait_for(2'h1, hi);
    cyc(20);
    note(2'h1, hi);
    want <= 6'h11;
    cyc(10);
    note(2'h2, 16'h0012);
    want <= 6'h19;
    wait_for(2'h1, lo);
    want <= 6'h0D;
    cyc(10);
    note(2'h2, 16'h0011);
    want <= 6'h21;
    cyc(10);
    want <= 6'h25;
    cyc(40);
    note(2'h1, lo);
    want <= 6'h05;
    wait_for(2'h1, hi);
    do_reset(16'h0000);
    want <= 6'h20;
    cyc(10);
    want <= 6'h21;
    cyc(40);
    note(2'h1, 16'h0000);
    note(2'h0, 16'h0000);
    $display("test stepping done");
    ret <= 1'b1;
    do_reset(16'h0013);
    want <= 6'h01;
    wait_for(2'h1, 16'h0013);
    // supply loss saves the live reference
    pf <= 1'b1;
    cyc(10);
    note(2'h3, 16'h0013);
    pf <= 1'b0;
    want <= 6'h21;
    cyc(10);
    do_reset(16'h0013);
    want <= 6'h20;
    cyc(10);
    want <= 6'h21;
    wait_for(2'h1, 16'h0013);
    $display("test retention done");
    cyc(2);
    finish_test();
  end
endmodule : testbench

bind dss_speed_select dss_sel_asserts #(
  .CYC_PER_MS(CYC_PER_MS),
  .JOG_MS(JOG_MS)
) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .term_i(term_i),
  .code_i(code_i), .freq_src_i(freq_src_i), .retain_en_i(retain_en_i),
  .jog_freq_i(jog_freq_i), .upper_lim_i(upper_lim_i), .run_o(run_o),
  .jog_stop_o(jog_stop_o), .freq_ref_o(freq_ref_o),
  .out_freq_o(out_freq_o), .input_config_error_o(input_config_error_o),
  .nv_save_o(nv_save_o));
`default_nettype wire
